/* File: hw/bsctp_pkg.sv */
// Package for the boundary-scan test port: TAP states, instruction codes, chain sizes
package bsctp_pkg;

    // TAP controller states
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h2,
        ST_CAP_DR   = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR   = 4'h8,
        ST_SEL_IR   = 4'h9,
        ST_CAP_IR   = 4'ha,
        ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc,
        ST_PAUSE_IR = 4'hd,
        ST_EXIT2_IR = 4'he,
        ST_UPD_IR   = 4'hf
    } bsctp_state_t;

    // Instruction register width and codes
    localparam int          IR_W        = 3;
    localparam logic [2:0]  IR_RESET    = 3'h7;
    localparam logic [2:0]  IR_CAPTURE  = 3'h1;
    localparam int          BSR_LEN     = 118;

    // Pin-side signals of the boundary chain
    typedef struct packed {
        logic [BSR_LEN-1:0] data;
    } bsctp_pins_t;

    // Instruction decode classes
    typedef enum logic [1:0] {
        OP_EXTEST = 2'h0,
        OP_SAMPLE = 2'h1,
        OP_BYPASS = 2'h2
    } bsctp_op_t;

endpackage : bsctp_pkg

/* File: hw/bsctp_top.sv */
// Boundary-scan test access port: TAP controller, instruction, bypass and boundary registers
//
// Operation
// - Implements standard boundary-scan architecture and TAP state machine.
// - Test clock independent of the system clock; scan never disturbs core.
// - Mode-select sampled on each rising test-clock edge to advance TAP.
// - Serial data input sampled on rising test-clock edge.
// - Undriven mode-select and data inputs read as one.
// - Input bits go into instruction or selected data register per state.
// - Data output shifts selected register serially, changing on falling edges.
// - Data output tristated when nothing is shifted.
// - Test reset resets TAP, instruction register and output enable; data registers keep their contents.
// - Instruction register loaded serially during shift-IR state.
// - Documented two-bit width reconciled by using three-bit instruction register.
// - Current instruction selects the data register on the scan path.
// - Codes 000-001 extest, 010-101 sample/preload, 110-111 bypass.
// - Bypass register is a single stage between data input and output.
// - Boundary register is a chain of 118 cells.
// - Boundary cell 0 is first bit shifted out.
// - Three-state control cells enable their drivers when holding one.
`timescale 1ns/10ps
module bsctp_top #(
    parameter int BSR_LEN = bsctp_pkg::BSR_LEN
) (
    // System clock and reset
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_n,
    // Test port pins, asynchronous to i_clk_sys
    input  wire logic               i_tck,
    input  wire logic               i_tms,
    input  wire logic               i_tms_oe_n,
    input  wire logic               i_tdi,
    input  wire logic               i_tdi_oe_n,
    input  wire logic               i_trst_n,
    output logic                    o_tdo,
    output logic                    o_tdo_oe_n,
    // Core and pin side of the boundary chain
    input  wire logic [BSR_LEN-1:0] i_core_out,
    input  wire logic [BSR_LEN-1:0] i_pin_in,
    output logic      [BSR_LEN-1:0] o_pin_out,
    output logic                    o_extest
);

    // Two-flop synchronisers for all scan pins; pull-ups applied after the second flop
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic       tck_d;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= 6'h3f;
            sync2 <= 6'h3f;
            // Idle-high value, so no false test-clock edge follows reset
            tck_d <= 1'b1;
        end else begin
            sync1 <= {i_tck, i_tms, i_tms_oe_n, i_tdi, i_tdi_oe_n, i_trst_n};
            sync2 <= sync1;
            tck_d <= sync2[5];
        end
    end

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_s_n;
    assign tck_s    = sync2[5];
    assign tms_s    = sync2[4] | sync2[3];
    assign tdi_s    = sync2[2] | sync2[1];
    assign trst_s_n = sync2[0];

    // Test-clock edges found as system-clock enables
    logic tck_rise;
    logic tck_fall;
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // Pin states pass two flops before capture; a pin moving during capture may read either level
    logic [BSR_LEN-1:0] pin_sync1;
    logic [BSR_LEN-1:0] pin_sync2;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
        end else begin
            pin_sync1 <= i_pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    // Instruction decode, used for path select and pin muxing
    function automatic bsctp_pkg::bsctp_op_t decode_op(input logic [bsctp_pkg::IR_W-1:0] code);
        if (code <= 3'h1) begin
            decode_op = bsctp_pkg::OP_EXTEST;
        end else if (code <= 3'h5) begin
            decode_op = bsctp_pkg::OP_SAMPLE;
        end else begin
            decode_op = bsctp_pkg::OP_BYPASS;
        end
    endfunction : decode_op

    bsctp_pkg::bsctp_state_t     state;
    bsctp_pkg::bsctp_state_t     next_state;
    // Three-bit instruction register so every decode code fits
    logic [bsctp_pkg::IR_W-1:0]  ir_shift;
    logic [bsctp_pkg::IR_W-1:0]  next_ir_shift;
    logic [bsctp_pkg::IR_W-1:0]  ir;
    logic [bsctp_pkg::IR_W-1:0]  next_ir;
    logic                        bypass;
    logic                        next_bypass;
    bsctp_pkg::bsctp_pins_t      bsr;
    bsctp_pkg::bsctp_pins_t      next_bsr;
    bsctp_pkg::bsctp_pins_t      upd;
    bsctp_pkg::bsctp_pins_t      next_upd;
    logic                        tdo;
    logic                        next_tdo;
    logic                        tdo_oe_n;
    logic                        next_tdo_oe_n;
    logic [BSR_LEN-1:0]          pin_out;
    logic [BSR_LEN-1:0]          next_pin_out;
    logic                        extest;
    logic                        next_extest;
    bsctp_pkg::bsctp_op_t        op;

    assign op = decode_op(ir);

    function automatic bsctp_pkg::bsctp_state_t tap_next(input bsctp_pkg::bsctp_state_t s, input logic tms);
        case (s)
            bsctp_pkg::ST_RESET:    tap_next = tms ? bsctp_pkg::ST_RESET   : bsctp_pkg::ST_IDLE;
            bsctp_pkg::ST_IDLE:     tap_next = tms ? bsctp_pkg::ST_SEL_DR  : bsctp_pkg::ST_IDLE;
            bsctp_pkg::ST_SEL_DR:   tap_next = tms ? bsctp_pkg::ST_SEL_IR  : bsctp_pkg::ST_CAP_DR;
            bsctp_pkg::ST_CAP_DR:   tap_next = tms ? bsctp_pkg::ST_EXIT1_DR : bsctp_pkg::ST_SHIFT_DR;
            bsctp_pkg::ST_SHIFT_DR: tap_next = tms ? bsctp_pkg::ST_EXIT1_DR : bsctp_pkg::ST_SHIFT_DR;
            bsctp_pkg::ST_EXIT1_DR: tap_next = tms ? bsctp_pkg::ST_UPD_DR  : bsctp_pkg::ST_PAUSE_DR;
            bsctp_pkg::ST_PAUSE_DR: tap_next = tms ? bsctp_pkg::ST_EXIT2_DR : bsctp_pkg::ST_PAUSE_DR;
            bsctp_pkg::ST_EXIT2_DR: tap_next = tms ? bsctp_pkg::ST_UPD_DR  : bsctp_pkg::ST_SHIFT_DR;
            bsctp_pkg::ST_UPD_DR:   tap_next = tms ? bsctp_pkg::ST_SEL_DR  : bsctp_pkg::ST_IDLE;
            bsctp_pkg::ST_SEL_IR:   tap_next = tms ? bsctp_pkg::ST_RESET   : bsctp_pkg::ST_CAP_IR;
            bsctp_pkg::ST_CAP_IR:   tap_next = tms ? bsctp_pkg::ST_EXIT1_IR : bsctp_pkg::ST_SHIFT_IR;
            bsctp_pkg::ST_SHIFT_IR: tap_next = tms ? bsctp_pkg::ST_EXIT1_IR : bsctp_pkg::ST_SHIFT_IR;
            bsctp_pkg::ST_EXIT1_IR: tap_next = tms ? bsctp_pkg::ST_UPD_IR  : bsctp_pkg::ST_PAUSE_IR;
            bsctp_pkg::ST_PAUSE_IR: tap_next = tms ? bsctp_pkg::ST_EXIT2_IR : bsctp_pkg::ST_PAUSE_IR;
            bsctp_pkg::ST_EXIT2_IR: tap_next = tms ? bsctp_pkg::ST_UPD_IR  : bsctp_pkg::ST_SHIFT_IR;
            bsctp_pkg::ST_UPD_IR:   tap_next = tms ? bsctp_pkg::ST_SEL_DR  : bsctp_pkg::ST_IDLE;
            default:                tap_next = bsctp_pkg::ST_RESET;
        endcase
    endfunction : tap_next

    always_comb begin
        next_state    = state;
        next_ir_shift = ir_shift;
        next_ir       = ir;
        next_bypass   = bypass;
        next_bsr      = bsr;
        next_upd      = upd;
        next_tdo      = tdo;
        next_tdo_oe_n = tdo_oe_n;
        if (!trst_s_n) begin
            // Test reset restores TAP reset state and bypass instruction
            next_state    = bsctp_pkg::ST_RESET;
            next_ir       = bsctp_pkg::IR_RESET;
            next_tdo_oe_n = 1'b1;
        end else if (tck_rise) begin
            next_state = tap_next(state, tms_s);
            case (state)
                bsctp_pkg::ST_RESET: begin
                    next_ir = bsctp_pkg::IR_RESET;
                end
                bsctp_pkg::ST_CAP_IR: begin
                    next_ir_shift = bsctp_pkg::IR_CAPTURE;
                end
                bsctp_pkg::ST_SHIFT_IR: begin
                    next_ir_shift = {tdi_s, ir_shift[bsctp_pkg::IR_W-1:1]};
                end
                bsctp_pkg::ST_UPD_IR: begin
                    next_ir = ir_shift;
                end
                bsctp_pkg::ST_CAP_DR: begin
                    // Capture pin states (bypass stage loads zero), no effect on operation
                    if (op == bsctp_pkg::OP_BYPASS) begin
                        next_bypass = 1'b0;
                    end else begin
                        next_bsr.data = pin_sync2;
                    end
                end
                // Data in sampled on rising edge
                bsctp_pkg::ST_SHIFT_DR: begin
                    if (op == bsctp_pkg::OP_BYPASS) begin
                        next_bypass = tdi_s;
                    end else begin
                        next_bsr.data = {tdi_s, bsr.data[BSR_LEN-1:1]};
                    end
                end
                bsctp_pkg::ST_UPD_DR: begin
                    if (op != bsctp_pkg::OP_BYPASS) begin
                        next_upd = bsr;
                    end
                end
                default: begin
                end
            endcase
        end else if (tck_fall) begin
            if (state == bsctp_pkg::ST_SHIFT_IR) begin
                next_tdo      = ir_shift[0];
                next_tdo_oe_n = 1'b0;
            end else if (state == bsctp_pkg::ST_SHIFT_DR) begin
                next_tdo      = (op == bsctp_pkg::OP_BYPASS) ? bypass : bsr.data[0];
                next_tdo_oe_n = 1'b0;
            end else begin
                next_tdo_oe_n = 1'b1;
            end
        end
    end

    // Extest drives pins from update latches, otherwise core passes through
    always_comb begin
        next_extest  = (op == bsctp_pkg::OP_EXTEST);
        next_pin_out = next_extest ? upd.data : i_core_out;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state    <= bsctp_pkg::ST_RESET;
            ir_shift <= '0;
            ir       <= bsctp_pkg::IR_RESET;
            bypass   <= 1'b0;
            bsr      <= '0;
            upd      <= '0;
            tdo      <= 1'b1;
            tdo_oe_n <= 1'b1;
            pin_out  <= '0;
            extest   <= 1'b0;
        end else begin
            state    <= next_state;
            ir_shift <= next_ir_shift;
            ir       <= next_ir;
            bypass   <= next_bypass;
            bsr      <= next_bsr;
            upd      <= next_upd;
            tdo      <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
            pin_out  <= next_pin_out;
            extest   <= next_extest;
        end
    end

    // Three-state control cells are active high, carried as-is to the pad enables
    assign o_pin_out  = pin_out;
    assign o_extest   = extest;
    assign o_tdo      = tdo;
    assign o_tdo_oe_n = tdo_oe_n;

    // Assertions
    a_trst_resets_tap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !trst_s_n |=> state == bsctp_pkg::ST_RESET)
        else $error("test reset did not reset TAP");
    a_tms_high_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && tms_s && state == bsctp_pkg::ST_SEL_IR) |=> state == bsctp_pkg::ST_RESET)
        else $error("TAP did not enter reset");
    a_tap_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && !tck_rise) |=> state == $past(state))
        else $error("TAP moved without rising test clock");
    a_tdo_tristate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_fall && state != bsctp_pkg::ST_SHIFT_DR && state != bsctp_pkg::ST_SHIFT_IR)
        |=> tdo_oe_n)
        else $error("data output driven outside shift");
    a_tdo_fall_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && !tck_fall) |=> $stable(tdo))
        else $error("data output changed off falling edge");
    a_ir_shift_in: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_SHIFT_IR) |=> ir_shift[bsctp_pkg::IR_W-1] == $past(tdi_s))
        else $error("instruction bit not shifted in");
    a_bypass_shift: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_SHIFT_DR && op == bsctp_pkg::OP_BYPASS)
        |=> bypass == $past(tdi_s))
        else $error("bypass stage wrong");
    a_cell0_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_fall && state == bsctp_pkg::ST_SHIFT_DR && op != bsctp_pkg::OP_BYPASS)
        |=> tdo == $past(bsr.data[0]))
        else $error("boundary cell 0 not shifted out");
    a_extest_pins: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (op == bsctp_pkg::OP_EXTEST) |=> o_pin_out == $past(upd.data))
        else $error("extest pins not from update latches");

    // Instruction path and test-reset output disable
    a_cap_ir_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_CAP_IR) |=> ir_shift == bsctp_pkg::IR_CAPTURE)
        else $error("instruction capture value not loaded");
    a_upd_ir_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_UPD_IR) |=> ir == $past(ir_shift))
        else $error("instruction not updated from shift stage");
    a_logic_reset_ir: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_RESET) |=> ir == bsctp_pkg::IR_RESET)
        else $error("logic reset did not restore bypass instruction");
    a_ir_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && !(tck_rise && (state == bsctp_pkg::ST_UPD_IR || state == bsctp_pkg::ST_RESET)))
        |=> $stable(ir))
        else $error("instruction changed outside update");
    a_trst_tristate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !trst_s_n |=> tdo_oe_n)
        else $error("test reset left data output driven");

    // Output path
    a_tdo_drive_shift: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_fall && (state == bsctp_pkg::ST_SHIFT_DR || state == bsctp_pkg::ST_SHIFT_IR))
        |=> !tdo_oe_n)
        else $error("data output not driven in shift");
    a_ir_first_out: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_fall && state == bsctp_pkg::ST_SHIFT_IR) |=> tdo == $past(ir_shift[0]))
        else $error("instruction stage not shifted out");
    a_bypass_out: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_fall && state == bsctp_pkg::ST_SHIFT_DR && op == bsctp_pkg::OP_BYPASS)
        |=> tdo == $past(bypass))
        else $error("bypass stage not shifted out");

    // Data path and pins
    a_bsr_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_CAP_DR && op != bsctp_pkg::OP_BYPASS)
        |=> bsr.data == $past(pin_sync2))
        else $error("pin states not captured");
    a_bsr_shift: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (trst_s_n && tck_rise && state == bsctp_pkg::ST_SHIFT_DR && op != bsctp_pkg::OP_BYPASS)
        |=> bsr.data == {$past(tdi_s), $past(bsr.data[BSR_LEN-1:1])})
        else $error("boundary chain did not shift by one cell");
    a_upd_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !(trst_s_n && tck_rise && state == bsctp_pkg::ST_UPD_DR) |=> $stable(upd))
        else $error("update latches changed outside update");
    a_core_pass: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (op != bsctp_pkg::OP_EXTEST) |=> o_pin_out == $past(i_core_out))
        else $error("core values not passed to pins");
    a_extest_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        1'b1 |=> o_extest == ($past(op) == bsctp_pkg::OP_EXTEST))
        else $error("extest flag does not follow instruction");

endmodule : bsctp_top

/* File: verif/bsctp_jtag_model.sv */
// Model of the external test-port controller that drives the scan pins
`timescale 1ns/10ps
module bsctp_jtag_model (
    // Scan pins driven towards the device
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tms_oe_n,
    output logic      o_tdi,
    output logic      o_tdi_oe_n,
    output logic      o_trst_n,
    // Scan output from the device
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe_n
);
    initial begin
        o_tck      = 1'b1;
        o_tms      = 1'b0;
        o_tms_oe_n = 1'b0;
        o_tdi      = 1'b1;
        o_tdi_oe_n = 1'b1;
        o_trst_n   = 1'b1;
    end

    // One test-clock period; the clock stands high between calls.
    // A floated pin is left at the level opposite its pull-up.
    task automatic step(input logic tms, input logic tdi, input logic [1:0] fl, output logic [1:0] seen);
        o_tck      = 1'b0;
        #1;
        o_tms      = tms & ~fl[1];
        o_tms_oe_n = fl[1];
        o_tdi      = tdi & ~fl[0];
        o_tdi_oe_n = fl[0];
        #79;
        o_tck      = 1'b1;
        #79;
        // Output launched by the last fall stands until the next fall
        seen       = {i_tdo_oe_n, i_tdo};
        #1;
    endtask : step

    task automatic release_tdi;
        o_tdi_oe_n = 1'b1;
        o_tdi      = ~o_tdi;
    endtask : release_tdi

    task automatic pulse_trst;
        o_trst_n = 1'b0;
        #200;
        o_trst_n = 1'b1;
        #100;
    endtask : pulse_trst
endmodule : bsctp_jtag_model

/* File: verif/tb.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
module tb;
    localparam int N = bsctp_pkg::BSR_LEN;
    logic         clk, rst_n, tck, tms, tms_oe_n, tdi, tdi_oe_n, trst_n, tdo, tdo_oe_n, extest;
    logic [N-1:0] core, pins, pout, pat, got;
    logic [1:0]   s;
    int           err_count = 0;
    int           check_count = 0;

    bsctp_top #(.BSR_LEN(N)) bsctp_top_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms),
        .i_tms_oe_n(tms_oe_n), .i_tdi(tdi), .i_tdi_oe_n(tdi_oe_n), .i_trst_n(trst_n), .o_tdo(tdo),
        .o_tdo_oe_n(tdo_oe_n), .i_core_out(core), .i_pin_in(pins), .o_pin_out(pout), .o_extest(extest));

    bsctp_jtag_model bsctp_jtag_model_i (.o_tck(tck), .o_tms(tms), .o_tms_oe_n(tms_oe_n), .o_tdi(tdi),
        .o_tdi_oe_n(tdi_oe_n), .o_trst_n(trst_n), .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n));

    task automatic check(input logic [N-1:0] seen, input logic [N-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stp(input logic tms_v, input logic tdi_v, input logic [1:0] fl);
        bsctp_jtag_model_i.step(tms_v, tdi_v, fl, s);
    endtask : stp

    // From idle: one instruction or data scan of n bits, first bit first, back to idle
    task automatic scan(input logic ir, input int n, input logic [N-1:0] din, output logic [N-1:0] dout);
        dout = '0;
        stp(1'b1, 1'b0, 2'h0);
        if (ir)
            stp(1'b1, 1'b0, 2'h0);
        stp(1'b0, 1'b0, 2'h0);
        stp(1'b0, 1'b0, 2'h0);
        for (int i = 0; i < n; i++) begin
            stp(i == n - 1, din[i], 2'h0);
            dout[i] = s[0];
            check(s[1], 1'b0);
        end
        stp(1'b1, 1'b0, 2'h0);
        check(s[1], 1'b1);
        stp(1'b0, 1'b0, 2'h0);
        bsctp_jtag_model_i.release_tdi();
    endtask : scan

    task automatic t_reset;
        check(tdo_oe_n, 1'b1);
        check(extest, 1'b0);
        check(pout, core);
        stp(1'b0, 1'b0, 2'h0);
        scan(1'b0, 8, N'(8'h2d), got);
        check(got[7:0], 8'h5a);
    endtask : t_reset

    // Every instruction code, with the register that it puts on the path
    task automatic t_codes;
        for (int c = 0; c < 8; c++) begin
            pat = ~core ^ (N'(c) << 50);
            scan(1'b1, 3, N'(c), got);
            check(got[2:0], 3'h1);
            check(extest, c < 2);
            if (c >= 6) begin
                scan(1'b0, 8, pat, got);
                check(got[7:0], {pat[6:0], 1'b0});
            end else begin
                scan(1'b0, N, pat, got);
                check(got, pins);
                repeat (3) @(posedge clk);
                #2;
                check(pout, c < 2 ? pat : core);
            end
        end
    endtask : t_codes

    // Undriven select and data pins must read as one
    task automatic t_float;
        scan(1'b1, 3, N'(0), got);
        repeat (5) stp(1'b0, 1'b0, 2'h2);
        stp(1'b0, 1'b0, 2'h0);
        check(extest, 1'b0);
        stp(1'b1, 1'b0, 2'h0);
        stp(1'b0, 1'b0, 2'h0);
        stp(1'b0, 1'b0, 2'h0);
        repeat (3) stp(1'b0, 1'b0, 2'h1);
        check(s[0], 1'b1);
        stp(1'b1, 1'b0, 2'h0);
        stp(1'b1, 1'b0, 2'h0);
        stp(1'b0, 1'b0, 2'h0);
    endtask : t_float

    // Test reset in mid-shift drops the driver and restores bypass
    task automatic t_trst;
        scan(1'b1, 3, N'(1), got);
        check(extest, 1'b1);
        stp(1'b1, 1'b0, 2'h0);
        stp(1'b0, 1'b0, 2'h0);
        repeat (3) stp(1'b0, 1'b1, 2'h0);
        check(s[1], 1'b0);
        bsctp_jtag_model_i.pulse_trst();
        check(tdo_oe_n, 1'b1);
        check(extest, 1'b0);
        stp(1'b0, 1'b0, 2'h0);
    endtask : t_trst

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        core  = {59{2'h1}};
        pins  = {59{2'h2}} ^ N'(8'h1f);
        repeat (10) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (5) @(posedge clk);
        // Pins move 2 or 3 ns after a clock edge, never on it
        #2;
        t_reset();
        t_codes();
        t_float();
        t_trst();
        summarize();
    end

    // Whole run needs well under half of this span
    initial begin
        #1000000;
        err_count++;
        summarize();
    end
endmodule : tb
